// ==== common/zbp_map.vh ====
/*
 * Constants for the zoned/packed decimal conversion datapath: widths,
 * control bits, zone codes, sign nibbles, sign characters and overpunch codes.
 * Assumes a byte-wide operand path and byte-counted field lengths.
 */
`ifndef ZBP_MAP_VH
`define ZBP_MAP_VH

// Widths
`define ZBP_LEN_W        16
`define ZBP_ST_W         3

// Control byte fields
`define ZBP_CTL_SEPSIGN  0
`define ZBP_CTL_FORCEPOS 1

// Zone nibbles
`define ZBP_ZONE_ASCII   4'h3
`define ZBP_ZONE_EBCDIC  4'hF

// Preferred sign nibbles
`define ZBP_POS_ASCII    4'hA
`define ZBP_NEG_ASCII    4'hB
`define ZBP_POS_EBCDIC   4'hC
`define ZBP_NEG_EBCDIC   4'hD

// Other accepted sign nibbles
`define ZBP_POS_ALT1     4'hE
`define ZBP_POS_ALT2     4'hF

// Separate sign characters
`define ZBP_SCH_POS_ASC  8'h2B
`define ZBP_SCH_NEG_ASC  8'h2D
`define ZBP_SCH_POS_EBC  8'h4E
`define ZBP_SCH_NEG_EBC  8'h60

// Overpunch codes
`define ZBP_OVP_POS_ZERO 8'h7B
`define ZBP_OVP_NEG_ZERO 8'h7D
`define ZBP_OVP_POS_BASE 8'h40
`define ZBP_OVP_NEG_BASE 8'h49
`define ZBP_OVP_NEG_HIGH 8'h50
`define ZBP_OVP_NEG_LOW  8'h4A
`define ZBP_OVP_POS_LOW  8'h41
`define ZBP_OVP_POS_HIGH 8'h49
`define ZBP_OVP_NEG_TOP  8'h52

`endif

// ==== src/zbp_core.v ====
/*
 * Pack (zoned to BCD) and unpack (BCD to zoned) string datapath.
 * Assumes a byte-wide operand path with a req/ack handshake on the
 * processor clock; byte index 0 is the rightmost byte of each field.
 */
`timescale 1ns/1ps
`include "zbp_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Packing strips zones of non-sign bytes, copies digit nibble unchecked.
// - ASCII overpunch pack decodes 30-39,7B,41-49 positive; 7D,4A-52 negative.
// - EBCDIC pack with both bits clear takes sign from upper nibble.
// - Preferred signs: ASCII A/B, EBCDIC C/D.
// - Invalid EBCDIC pack sign leaves the sign nibble free.
// - Bit 0 set, bit 1 clear: rightmost byte is a sign character.
// - Bad sign character leaves the whole result field free.
// - Detected sign character writes the preferred sign nibble.
// - Both bits set forces preferred positive sign; unpack writes the source sign character and raises sign_fault if negative.
// - Unpack zone is 3 in ASCII, F in EBCDIC.
// - Unpack takes sign from packed sign nibble, digits right to left.
// - Short unpack source fills high result bytes with zoned zero.
// - Long unpack source drops excess high-order digits.
// - ASCII overpunch unpack: positive 7B,41-49; negative 7D,4A-52.
// - Invalid sign in ASCII overpunch unpack leaves rightmost byte free.
// - Short pack source fills high result digits with zero.
// - Long pack source drops excess high-order digits.
// - Signs A,C,E,F positive; B,D negative; only these six valid.
// - Pack lengths are byte counts; both are given.
module zbp_core (
   input  wire                   clk,
   input  wire                   rst,
   input  wire                   start,
   input  wire                   op_unpack,
   input  wire                   ascii_mode,
   input  wire [1:0]             ctrl,
   input  wire [`ZBP_LEN_W-1:0]  src_len,
   input  wire [`ZBP_LEN_W-1:0]  dst_len,
   output wire                   rd_req,
   output wire [`ZBP_LEN_W-1:0]  rd_idx,
   input  wire                   rd_ack,
   input  wire [7:0]             rd_data,
   output wire                   wr_req,
   output wire [`ZBP_LEN_W-1:0]  wr_idx,
   output wire [7:0]             wr_data,
   input  wire                   wr_ack,
   output wire                   busy,
   output wire                   done,
   output wire                   sign_fault
);

   localparam [`ZBP_ST_W-1:0] ST_IDLE  = 3'd0;
   localparam [`ZBP_ST_W-1:0] ST_FETCH = 3'd1;
   localparam [`ZBP_ST_W-1:0] ST_RWAIT = 3'd2;
   localparam [`ZBP_ST_W-1:0] ST_PROC  = 3'd3;
   localparam [`ZBP_ST_W-1:0] ST_WWAIT = 3'd4;

   reg [`ZBP_ST_W-1:0]  state_reg;
   reg                  unp_reg;
   reg                  asc_reg;
   reg [1:0]            ctl_reg;
   reg [`ZBP_LEN_W-1:0] slen_reg;
   reg [`ZBP_LEN_W-1:0] dlen_reg;
   reg [`ZBP_LEN_W-1:0] sidx_reg;
   reg [`ZBP_LEN_W-1:0] didx_reg;
   reg                  first_reg;
   reg                  half_reg;
   reg [3:0]            acc_reg;
   reg [7:0]            sbyte_reg;
   reg                  rd_req_reg;
   reg [`ZBP_LEN_W-1:0] rd_idx_reg;
   reg                  wr_req_reg;
   reg [`ZBP_LEN_W-1:0] wr_idx_reg;
   reg [7:0]            wr_data_reg;
   reg                  busy_reg;
   reg                  done_reg;
   reg                  fault_reg;

   assign rd_req     = rd_req_reg;
   assign rd_idx     = rd_idx_reg;
   assign wr_req     = wr_req_reg;
   assign wr_idx     = wr_idx_reg;
   assign wr_data    = wr_data_reg;
   assign busy       = busy_reg;
   assign done       = done_reg;
   assign sign_fault = fault_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Sign and digit translation

   wire       g_sep  = ctl_reg[`ZBP_CTL_SEPSIGN];
   wire       g_pos  = ctl_reg[`ZBP_CTL_FORCEPOS];
   wire [3:0] pref_p = asc_reg ? `ZBP_POS_ASCII : `ZBP_POS_EBCDIC;
   wire [3:0] pref_n = asc_reg ? `ZBP_NEG_ASCII : `ZBP_NEG_EBCDIC;
   wire [7:0] sch_p  = asc_reg ? `ZBP_SCH_POS_ASC : `ZBP_SCH_POS_EBC;
   wire [7:0] sch_n  = asc_reg ? `ZBP_SCH_NEG_ASC : `ZBP_SCH_NEG_EBC;
   wire [3:0] zone   = asc_reg ? `ZBP_ZONE_ASCII : `ZBP_ZONE_EBCDIC;

   // Packed sign nibble of the rightmost source byte
   wire [3:0] up_sn  = sbyte_reg[3:0];
   wire [3:0] up_d0  = sbyte_reg[7:4];
   wire       up_neg = (up_sn == `ZBP_NEG_ASCII) || (up_sn == `ZBP_NEG_EBCDIC);
   wire [7:0] ovp_off = sbyte_reg - `ZBP_OVP_NEG_BASE;

   reg  [3:0] pk_sign;
   reg  [3:0] pk_dig;
   reg        pk_has;
   reg  [7:0] up_first;

   // First pack byte: yields the sign and possibly the least significant digit
   always @*
   begin
      pk_sign = pref_p;
      pk_dig  = sbyte_reg[3:0];
      pk_has  = 1'b1;
      if (g_sep && g_pos)
      begin
         pk_sign = pref_p;
      end
      else if (g_sep)
      begin
         // Anything else is taken as a zoned digit; bad bytes are free
         if (sbyte_reg == sch_p)
         begin
            pk_sign = pref_p;
            pk_has  = 1'b0;
         end
         else if (sbyte_reg == sch_n)
         begin
            pk_sign = pref_n;
            pk_has  = 1'b0;
         end
      end
      else if (asc_reg)
      begin
         // Bit 1 alone is never issued, so it follows the bits-clear path
         if (sbyte_reg == `ZBP_OVP_POS_ZERO)
            pk_dig = 4'h0;
         else if (sbyte_reg == `ZBP_OVP_NEG_ZERO)
         begin
            pk_dig  = 4'h0;
            pk_sign = pref_n;
         end
         else if (sbyte_reg >= `ZBP_OVP_NEG_LOW && sbyte_reg <= `ZBP_OVP_NEG_TOP)
         begin
            pk_dig  = ovp_off[3:0];
            pk_sign = pref_n;
         end
         else if (sbyte_reg >= `ZBP_OVP_POS_LOW && sbyte_reg <= `ZBP_OVP_POS_HIGH)
            pk_dig = sbyte_reg[3:0];
      end
      else
      begin
         // Unrecognised sign nibbles default to positive
         if (sbyte_reg[7:4] == `ZBP_NEG_ASCII || sbyte_reg[7:4] == `ZBP_NEG_EBCDIC)
            pk_sign = pref_n;
         else
            pk_sign = pref_p;
      end
   end

   // First unpack byte: sign character, overpunch or zoned sign
   always @*
   begin
      up_first = {pref_p, up_d0};
      if (g_sep)
         up_first = up_neg ? sch_n : sch_p;
      else if (asc_reg)
      begin
         // Invalid sign nibbles fall into the positive row
         if (up_d0 == 4'h0)
            up_first = up_neg ? `ZBP_OVP_NEG_ZERO : `ZBP_OVP_POS_ZERO;
         else if (up_neg)
            up_first = `ZBP_OVP_NEG_BASE + {4'h0, up_d0};
         else
            up_first = `ZBP_OVP_POS_BASE + {4'h0, up_d0};
      end
      else
         up_first = {(up_neg ? pref_n : pref_p), up_d0};
   end

   wire [3:0] up_dig = half_reg ? sbyte_reg[7:4] : sbyte_reg[3:0];
   wire       last_w = (didx_reg + 16'h0001) == dlen_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg   <= ST_IDLE;
         unp_reg     <= 1'b0;
         asc_reg     <= 1'b0;
         ctl_reg     <= 2'b00;
         slen_reg    <= 16'h0000;
         dlen_reg    <= 16'h0000;
         sidx_reg    <= 16'h0000;
         didx_reg    <= 16'h0000;
         first_reg   <= 1'b0;
         half_reg    <= 1'b0;
         acc_reg     <= 4'h0;
         sbyte_reg   <= 8'h00;
         rd_req_reg  <= 1'b0;
         rd_idx_reg  <= 16'h0000;
         wr_req_reg  <= 1'b0;
         wr_idx_reg  <= 16'h0000;
         wr_data_reg <= 8'h00;
         busy_reg    <= 1'b0;
         done_reg    <= 1'b0;
         fault_reg   <= 1'b0;
      end
      else
      begin
         done_reg <= 1'b0;
         case (state_reg)
            ST_IDLE:
            begin
               if (start)
               begin
                  unp_reg   <= op_unpack;
                  asc_reg   <= ascii_mode;
                  ctl_reg   <= ctrl;
                  slen_reg  <= src_len;
                  dlen_reg  <= dst_len;
                  sidx_reg  <= 16'h0000;
                  didx_reg  <= 16'h0000;
                  first_reg <= 1'b1;
                  half_reg  <= 1'b0;
                  fault_reg <= 1'b0;
                  // An empty result field finishes at once
                  if (dst_len == 16'h0000)
                     done_reg <= 1'b1;
                  else
                  begin
                     busy_reg  <= 1'b1;
                     state_reg <= ST_FETCH;
                  end
               end
            end
            ST_FETCH:
            begin
               sidx_reg <= sidx_reg + 16'h0001;
               if (sidx_reg < slen_reg)
               begin
                  rd_req_reg <= 1'b1;
                  rd_idx_reg <= sidx_reg;
                  state_reg  <= ST_RWAIT;
               end
               else
               begin
                  // Source exhausted: zero digits pad the high end
                  sbyte_reg <= 8'h00;
                  state_reg <= ST_PROC;
               end
            end
            ST_RWAIT:
            begin
               if (rd_ack)
               begin
                  rd_req_reg <= 1'b0;
                  sbyte_reg  <= rd_data;
                  state_reg  <= ST_PROC;
               end
            end
            ST_PROC:
            begin
               first_reg <= 1'b0;
               state_reg <= ST_FETCH;
               if (unp_reg)
               begin
                  wr_req_reg <= 1'b1;
                  wr_idx_reg <= didx_reg;
                  state_reg  <= ST_WWAIT;
                  if (first_reg)
                  begin
                     wr_data_reg <= up_first;
                     half_reg    <= g_sep;
                     fault_reg   <= g_sep & g_pos & up_neg;
                  end
                  else
                  begin
                     wr_data_reg <= {zone, up_dig};
                     half_reg    <= ~half_reg;
                  end
               end
               else if (first_reg)
               begin
                  if (pk_has)
                  begin
                     wr_req_reg  <= 1'b1;
                     wr_idx_reg  <= didx_reg;
                     wr_data_reg <= {pk_dig, pk_sign};
                     state_reg   <= ST_WWAIT;
                  end
                  else
                  begin
                     acc_reg  <= pk_sign;
                     half_reg <= 1'b1;
                  end
               end
               else if (half_reg)
               begin
                  wr_req_reg  <= 1'b1;
                  wr_idx_reg  <= didx_reg;
                  wr_data_reg <= {sbyte_reg[3:0], acc_reg};
                  half_reg    <= 1'b0;
                  state_reg   <= ST_WWAIT;
               end
               else
               begin
                  acc_reg  <= sbyte_reg[3:0];
                  half_reg <= 1'b1;
               end
            end
            ST_WWAIT:
            begin
               if (wr_ack)
               begin
                  wr_req_reg <= 1'b0;
                  didx_reg   <= didx_reg + 16'h0001;
                  // Stopping at the result length drops surplus digits
                  if (last_w)
                  begin
                     busy_reg  <= 1'b0;
                     done_reg  <= 1'b1;
                     state_reg <= ST_IDLE;
                  end
                  else if (unp_reg && half_reg)
                     state_reg <= ST_PROC;
                  else
                     state_reg <= ST_FETCH;
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

// ==== bench/zbp_core_asserts.sv ====
/* Checker for the zbp_core memory handshakes and result fields.
   Bound to every zbp_core; sees only its ports. */
`timescale 1ns/1ps
`include "zbp_map.vh"
module zbp_core_asserts (
   input wire                  clk,
   input wire                  rst,
   input wire                  start,
   input wire                  op_unpack,
   input wire                  ascii_mode,
   input wire [1:0]            ctrl,
   input wire [`ZBP_LEN_W-1:0] src_len,
   input wire [`ZBP_LEN_W-1:0] dst_len,
   input wire                  rd_req,
   input wire [`ZBP_LEN_W-1:0] rd_idx,
   input wire                  rd_ack,
   input wire                  wr_req,
   input wire [`ZBP_LEN_W-1:0] wr_idx,
   input wire [7:0]            wr_data,
   input wire                  wr_ack,
   input wire                  busy,
   input wire                  done
);
   localparam W = `ZBP_LEN_W;
   reg [W-1:0] sl_reg, dl_reg, cnt_reg;
   reg         up_reg, as_reg;
   reg [1:0]   ct_reg;
   wire        take = start && !busy;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   // Fields taken with start; the write count is the next expected index
   always @(posedge clk)
   begin
      if (take)
         {up_reg, as_reg, ct_reg, sl_reg, dl_reg} <=
            {op_unpack, ascii_mode, ctrl, src_len, dst_len};
      cnt_reg <= take ? {W{1'b0}} : cnt_reg + {{(W-1){1'b0}}, wr_req & wr_ack};
   end
   chk_rd_hold: assert property (rd_req && !rd_ack |=> rd_req && $stable(rd_idx))
      else $error("read request not held");
   chk_rd_drop: assert property (rd_req && rd_ack |=> !rd_req)
      else $error("read request kept after ack");
   chk_wr_hold: assert property (wr_req && !wr_ack |=>
      wr_req && $stable({wr_idx, wr_data}))
      else $error("write request not held");
   chk_one_req: assert property (!(rd_req && wr_req))
      else $error("read and write open together");
   chk_rd_range: assert property (rd_req |-> rd_idx < sl_reg)
      else $error("read beyond source field");
   chk_wr_order: assert property (wr_req |-> wr_idx == cnt_reg && wr_idx < dl_reg)
      else $error("write index out of order");
   chk_done_count: assert property (done |-> (cnt_reg == dl_reg && !busy) ##1 !done)
      else $error("done without all writes");
   chk_empty_done: assert property (take && dst_len == 0 |=> done)
      else $error("empty result not done at once");
   chk_unpack_zone: assert property (wr_req && up_reg && wr_idx != 0 |->
      wr_data[7:4] == (as_reg ? `ZBP_ZONE_ASCII : `ZBP_ZONE_EBCDIC))
      else $error("wrong unpack zone");
   chk_force_pos: assert property (wr_req && !up_reg && ct_reg == 2'b11 &&
      wr_idx == 0 |-> wr_data[3:0] == (as_reg ? `ZBP_POS_ASCII : `ZBP_POS_EBCDIC))
      else $error("forced sign not positive");
endmodule

bind zbp_core zbp_core_asserts i_chk (.clk(clk), .rst(rst), .start(start),
   .op_unpack(op_unpack), .ascii_mode(ascii_mode), .ctrl(ctrl), .src_len(src_len),
   .dst_len(dst_len), .rd_req(rd_req), .rd_idx(rd_idx), .rd_ack(rd_ack), .wr_req(wr_req),
   .wr_idx(wr_idx), .wr_data(wr_data), .wr_ack(wr_ack), .busy(busy), .done(done));

// ==== bench/zbp_mem_model.sv ====
/* Operand memory: source bytes in src, result bytes in dst.
   Assumes one open request at a time, as the core promises. */
`timescale 1ns/1ps
module zbp_mem_model (
   input  wire        clk,
   input  wire        rst,
   input  wire [1:0]  lat,
   input  wire        rd_req,
   input  wire [15:0] rd_idx,
   output wire        rd_ack,
   output wire [7:0]  rd_data,
   input  wire        wr_req,
   input  wire [15:0] wr_idx,
   input  wire [7:0]  wr_data,
   output wire        wr_ack
);
   reg [7:0] src [0:15];
   reg [7:0] dst [0:15];
   reg [1:0] wait_reg;
   reg [7:0] junk_reg;
   // Answer after lat cycles; data is noise outside an ack so stale bytes never match
   assign rd_ack  = rd_req && wait_reg == lat;
   assign wr_ack  = wr_req && wait_reg == lat;
   assign rd_data = rd_ack ? src[rd_idx[3:0]] : junk_reg;
   always @(posedge clk or posedge rst)
      if (rst)
      begin
         wait_reg <= 2'h0;
         junk_reg <= 8'ha5;
      end
      else
      begin
         wait_reg <= (rd_req || wr_req) && !(rd_ack || wr_ack) ? wait_reg + 2'h1 : 2'h0;
         junk_reg <= {junk_reg[6:0], ~junk_reg[7]};
         if (wr_ack)
            dst[wr_idx[3:0]] <= wr_data;
      end
endmodule

// ==== bench/zbp_core_test.sv ====
/* Self-checking bench for zbp_core against the memory model.
   Needs zbp_map.vh on the include path. */
`timescale 1ns/1ps
module zbp_core_test;
   reg         clk = 1'b0, rst = 1'b1, start = 1'b0, op_unpack = 1'b0, ascii_mode = 1'b0;
   reg  [1:0]  ctrl = 2'h0, lat = 2'h0;
   reg  [15:0] src_len = 16'h0000, dst_len = 16'h0000;
   wire        rd_req, rd_ack, wr_req, wr_ack, busy, done, sign_fault;
   wire [15:0] rd_idx, wr_idx;
   wire [7:0]  rd_data, wr_data;
   int         n_mismatch, total_checks, d, i;
   logic [15:0] sp [4] = '{16'h362b, 16'h362d, 16'hf64e, 16'hf660};
   logic [3:0]  sgn [4] = '{4'ha, 4'hb, 4'hc, 4'hd};
   logic [39:0] ex;

   zbp_core i_zbp_core (.clk(clk), .rst(rst), .start(start), .op_unpack(op_unpack),
      .ascii_mode(ascii_mode), .ctrl(ctrl), .src_len(src_len), .dst_len(dst_len),
      .rd_req(rd_req), .rd_idx(rd_idx), .rd_ack(rd_ack), .rd_data(rd_data), .wr_req(wr_req),
      .wr_idx(wr_idx), .wr_data(wr_data), .wr_ack(wr_ack), .busy(busy), .done(done),
      .sign_fault(sign_fault));
   zbp_mem_model i_zbp_mem_model (.clk(clk), .rst(rst), .lat(lat), .rd_req(rd_req),
      .rd_idx(rd_idx), .rd_ack(rd_ack), .rd_data(rd_data), .wr_req(wr_req), .wr_idx(wr_idx),
      .wr_data(wr_data), .wr_ack(wr_ack));

   always #2 clk = ~clk;
   ////////////////////////////////////////
   task conclude;
   begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask

   task chk(input string what, input logic [7:0] exp, got);
   begin
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   end
   endtask

   function automatic logic [7:0] ovp(input logic neg, input logic [3:0] v);
      ovp = v == 0 ? (neg ? 8'h7d : 8'h7b) : (neg ? 8'h49 : 8'h40) + {4'h0, v};
   endfunction

   // Result bytes start as a marker, so a missing or extra write shows
   task run(input logic u, a, input logic [1:0] c, input logic [15:0] sl, dl);
      int n;
   begin
      for (n = 0; n < 16; n++)
         i_zbp_mem_model.dst[n] = 8'hee;
      @(posedge clk);
      start <= 1'b1;
      op_unpack <= u;
      ascii_mode <= a;
      ctrl <= c;
      src_len <= sl;
      dst_len <= dl;
      n = 0;
      do
      begin
         @(posedge clk);
         start <= 1'b0;
         #1 n++;
      end while (done !== 1'b1 && n < 300);
      chk("done", 8'h01, {7'h0, done});
   end
   endtask

   task t1(input string what, input logic [31:0] s, input logic u, a, input logic [1:0] c,
           input logic [15:0] sl, dl, input logic [7:0] exp);
      int k;
   begin
      for (k = 0; k < 4; k++)
         i_zbp_mem_model.src[k] = s[8*k +: 8];
      run(u, a, c, sl, dl);
      chk(what, exp, i_zbp_mem_model.dst[0]);
   end
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (d = 0; d < 10; d++)
      begin
         t1("ovp pos", {24'h0, ovp(0, d[3:0])}, 0, 1, 0, 1, 1, {d[3:0], 4'ha});
         t1("ovp neg", {24'h0, ovp(1, d[3:0])}, 0, 1, 0, 1, 1, {d[3:0], 4'hb});
         t1("ovp dig", {24'h3, d[3:0]}, 0, 1, 0, 1, 1, {d[3:0], 4'ha});
         t1("unp pos", {24'h0, d[3:0], 4'hf}, 1, 1, 0, 1, 1, ovp(0, d[3:0]));
         t1("unp neg", {24'h0, d[3:0], 4'hb}, 1, 1, 0, 1, 1, ovp(1, d[3:0]));
      end
      $display("test overpunch done");
      lat = 2'h1;
      for (i = 10; i < 16; i++)
         t1("ebc sign", {24'h0, i[3:0], 4'h7}, 0, 0, 0, 1, 1,
            {4'h7, (i == 11 || i == 13) ? 4'hd : 4'hc});
      for (i = 0; i < 4; i++)
         t1("sep pack", {16'h0, sp[i]}, 0, i < 2, 1, 2, 1, {4'h6, sgn[i]});
      $display("test pack signs done");
      lat = 2'h2;
      t1("pack lo", 32'h0039_f7d5, 0, 0, 0, 3, 3, 8'h5d);
      chk("pack mid", 8'h97, i_zbp_mem_model.dst[1]);
      chk("pack pad", 8'h00, i_zbp_mem_model.dst[2]);
      chk("pack end", 8'hee, i_zbp_mem_model.dst[3]);
      t1("pack cut", 32'hf4f3_f2c1, 0, 0, 0, 4, 1, 8'h1c);
      chk("pack cut end", 8'hee, i_zbp_mem_model.dst[1]);
      for (i = 0; i < 2; i++)
      begin
         run(0, i[0], 3, 1, 1);
         chk("force", i ? 8'h0a : 8'h0c, {4'h0, i_zbp_mem_model.dst[0][3:0]});
      end
      $display("test pack fields done");
      lat = 2'h0;
      t1("unp lo", 32'h0000_216d, 1, 1, 0, 2, 5, 8'h4f);
      ex = 40'h30_3032_314f;
      for (i = 1; i < 5; i++)
         chk("unp hi", ex[8*i +: 8], i_zbp_mem_model.dst[i]);
      t1("unp ebc", 32'h0099_875c, 1, 0, 0, 3, 2, 8'hc5);
      chk("unp cut", 8'hf7, i_zbp_mem_model.dst[1]);
      chk("unp end", 8'hee, i_zbp_mem_model.dst[2]);
      t1("unp sep", 32'h0000_123b, 1, 1, 1, 2, 3, 8'h2d);
      chk("unp sep d0", 8'h33, i_zbp_mem_model.dst[1]);
      t1("unp flt", 32'h0000_007d, 1, 0, 3, 1, 2, 8'h60);
      chk("fault", 8'h01, {7'h0, sign_fault});
      t1("empty", 32'h0000_0031, 0, 1, 0, 1, 0, 8'hee);
      $display("test unpack done");
      conclude;
   end

   // About 515 cycles are expected; this cuts a hang off far beyond that
   initial
   begin
      #100000;
      n_mismatch++;
      conclude;
   end
endmodule
